// File: shared/sdram_burst_pkg.sv
// constants and types for the sdram burst, precharge and power-down engine
package sdram_burst_pkg;
   // command codes {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP       = 4'h7;
   localparam logic [3:0] CMD_ACTIVE    = 4'h3;
   localparam logic [3:0] CMD_READ      = 4'h5;
   localparam logic [3:0] CMD_WRITE     = 4'h4;
   localparam logic [3:0] CMD_TERMINATE = 4'h6;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   // timing in ns and derived cycle counts at 100 MHz
   localparam int CLK_PERIOD_NS        = 10;
   localparam int PRECHARGE_PERIOD_NS  = 20;
   localparam int WRITE_RECOVERY_NS    = 15;
   localparam int PRECHARGE_CYCLES     = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_RECOVERY_CYCLES = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] TIMER_RESET  = 4'h0;
   localparam logic [2:0] BURST_FULL_PAGE = 3'h7;
   localparam logic [1:0] CAS_LATENCY_DEFAULT = 2'h2;
   localparam logic [2:0] BURST_LENGTH_CODE_DEFAULT = 3'h2;
   localparam int ALL_BANK_BIT         = 10;
   localparam int NUM_BANKS            = 4;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_READ  = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_PDOWN = 4'b1000
   } burst_state_t;
endpackage

// File: src/sdram_burst_engine.sv
// sdram command engine: bursts, truncation, precharge, power-down
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - write after read floats data lines
// - precharge may truncate read, cl-1 early
// - burst terminate cuts read, cl-1 early
// - write data captured from command edge on
// - finished write burst ignores further data
// - full page wraps to column zero
// - new write truncates, data belongs to it
// - read during write stops further writes
// - terminate ignores data with that command
// - all-bank bit selects one or all banks
// - precharged bank idle until activated again
// - clock-gate low with nop enters power-down
// - power-down disables buffers except clock-gate
// - clock-gate high with nop exits power-down
module sdram_burst_engine #(
   parameter int DATA_WIDTH = 16,
   parameter int COL_WIDTH  = 9,
   parameter int ROW_WIDTH  = 12
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire logic                  clock_gate,
   input  wire logic                  cs_n,
   input  wire logic                  ras_n,
   input  wire logic                  cas_n,
   input  wire logic                  we_n,
   input  wire logic [1:0]            bank_select_inputs,
   input  wire logic [ROW_WIDTH-1:0]  addr,
   input  wire logic                  dqm,
   input  wire logic [DATA_WIDTH-1:0] dq_in,
   input  wire logic [1:0]            cas_latency,
   input  wire logic [2:0]            burst_length_code,
   output logic [DATA_WIDTH-1:0]      dq_out,
   output logic                       dq_oe_n,
   output logic                       wr_en,
   output logic [1:0]                 wr_bank,
   output logic [COL_WIDTH-1:0]       wr_col,
   output logic [DATA_WIDTH-1:0]      wr_data,
   output logic                       rd_en,
   output logic [1:0]                 rd_bank,
   output logic [COL_WIDTH-1:0]       rd_col,
   output logic [3:0]                 bank_open,
   output logic                       power_down,
   output logic                       active_power_down,
   output logic                       cmd_error
);
   if (COL_WIDTH < 4 || COL_WIDTH > sdram_burst_pkg::ALL_BANK_BIT ||
       ROW_WIDTH <= sdram_burst_pkg::ALL_BANK_BIT || DATA_WIDTH < 1) begin : g_bad_widths
      $error("sdram_burst_engine: unsupported address widths");
   end

   // ***********************************************
   // input synchronisers (pins come from outside)
   // ***********************************************
   logic [ROW_WIDTH+DATA_WIDTH+7:0] pin_meta;
   logic [ROW_WIDTH+DATA_WIDTH+7:0] pin_sync;
   logic [ROW_WIDTH+DATA_WIDTH+7:0] pin_raw;
   assign pin_raw = {clock_gate, cs_n, ras_n, cas_n, we_n, bank_select_inputs, addr, dqm, dq_in};

   always_ff @(posedge sys_clk) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
   end

   logic                  s_cke;
   logic [3:0]            s_cmd;
   logic [1:0]            s_ba;
   logic [ROW_WIDTH-1:0]  s_addr;
   logic                  s_dqm;
   logic [DATA_WIDTH-1:0] s_dq;
   assign {s_cke, s_cmd, s_ba, s_addr, s_dqm, s_dq} = pin_sync;

   function automatic logic [COL_WIDTH-1:0] burst_len(input logic [2:0] code);
      burst_len = (code == sdram_burst_pkg::BURST_FULL_PAGE) ? '0 : COL_WIDTH'(1) << code;
   endfunction

   // ***********************************************
   // state
   // ***********************************************
   sdram_burst_pkg::burst_state_t state, next_state;
   logic [COL_WIDTH-1:0]  col, next_col;
   logic [COL_WIDTH-1:0]  left, next_left;
   logic [1:0]            bank, next_bank;
   logic                  full_page, next_full_page;
   logic [3:0]            open_q, next_open;
   logic [3:0]            timer [4];
   logic [3:0]            next_timer [4];
   logic [3:0]            rd_pipe, next_rd_pipe;
   logic                  dqm_prev, next_dqm_prev;
   logic                  float_hold, next_float_hold;
   logic                  next_wr_en, next_rd_en, next_oe_n, next_error;
   logic [DATA_WIDTH-1:0] next_wr_data;
   logic                  next_pd, next_apd;
   logic [1:0]            dqm_pipe, next_dqm_pipe;
   logic                  cke_prev, next_cke_prev;

   always_comb begin
      next_state      = state;
      next_col        = col;
      next_left       = left;
      next_bank       = bank;
      next_full_page  = full_page;
      next_open       = open_q;
      next_dqm_prev   = s_dqm;
      next_cke_prev   = s_cke;
      next_float_hold = float_hold;
      next_wr_en      = 1'b0;
      next_rd_en      = 1'b0;
      next_wr_data    = s_dq;
      next_error      = 1'b0;
      next_pd         = power_down;
      next_apd        = active_power_down;
      next_dqm_pipe   = {dqm_pipe[0], s_dqm};
      next_rd_pipe    = {rd_pipe[2:0], 1'b0};
      for (int b = 0; b < 4; b++) begin
         next_timer[b] = (timer[b] != 4'h0) ? timer[b] - 4'h1 : 4'h0;
      end

      unique case (state)
         sdram_burst_pkg::ST_PDOWN: begin
            // buffers off: only clock gate high with nop or inhibit is looked at
            next_rd_pipe = '0;
            if (s_cke && s_cmd[3:0] == sdram_burst_pkg::CMD_NOP || s_cke && s_cmd[3]) begin
               next_state = sdram_burst_pkg::ST_IDLE;
               next_pd    = 1'b0;
               next_apd   = 1'b0;
            end
         end
         default: begin
            // bursts advance every edge; full page wraps
            if (state != sdram_burst_pkg::ST_IDLE) begin
               if (state == sdram_burst_pkg::ST_WRITE) begin
                  next_wr_en = !s_dqm;
                  if (!s_dqm) next_timer[bank] = 4'(sdram_burst_pkg::WRITE_RECOVERY_CYCLES - 1);
               end else begin
                  next_rd_pipe[0] = 1'b1;
               end
               next_col = col + COL_WIDTH'(1);
               if (!full_page) begin
                  next_left = left - COL_WIDTH'(1);
                  if (left == COL_WIDTH'(1)) next_state = sdram_burst_pkg::ST_IDLE;
               end
            end
            if (s_cmd[3]) begin
               // command inhibit; power-down entry only with no burst running
               if (!s_cke && cke_prev && state == sdram_burst_pkg::ST_IDLE) begin
                  next_state = sdram_burst_pkg::ST_PDOWN;
                  next_pd    = 1'b1;
                  next_apd   = |open_q;
               end
            end else begin
               unique case (s_cmd)
                  sdram_burst_pkg::CMD_NOP: begin
                     if (!s_cke && cke_prev && state == sdram_burst_pkg::ST_IDLE) begin
                        next_state = sdram_burst_pkg::ST_PDOWN;
                        next_pd    = 1'b1;
                        next_apd   = |open_q;
                     end
                  end
                  sdram_burst_pkg::CMD_ACTIVE: begin
                     if (open_q[s_ba] || timer[s_ba] != 4'h0) next_error = 1'b1;
                     else next_open[s_ba] = 1'b1;
                  end
                  sdram_burst_pkg::CMD_READ, sdram_burst_pkg::CMD_WRITE: begin
                     if (!open_q[s_ba]) begin
                        next_error = 1'b1;
                     end else begin
                        next_bank      = s_ba;
                        next_full_page = burst_length_code == sdram_burst_pkg::BURST_FULL_PAGE;
                        next_left      = burst_len(burst_length_code) - COL_WIDTH'(1);
                        next_col       = s_addr[COL_WIDTH-1:0] + COL_WIDTH'(1);
                        if (s_cmd == sdram_burst_pkg::CMD_WRITE) begin
                           // write after read floats output if mask was up
                           if (state == sdram_burst_pkg::ST_READ || rd_pipe != '0) begin
                              if (dqm_prev) next_float_hold = 1'b1;
                              else next_error = 1'b1;
                           end
                           next_rd_pipe = '0;
                           // first element on the command edge
                           next_wr_en = !s_dqm;
                           if (!s_dqm) next_timer[s_ba] = 4'(sdram_burst_pkg::WRITE_RECOVERY_CYCLES - 1);
                           next_state = (next_left == '0 && !next_full_page) ?
                              sdram_burst_pkg::ST_IDLE : sdram_burst_pkg::ST_WRITE;
                        end else begin
                           // read cancels any pending writes
                           next_wr_en      = 1'b0;
                           next_float_hold = 1'b0;
                           next_rd_pipe[0] = 1'b1;
                           next_state = (next_left == '0 && !next_full_page) ?
                              sdram_burst_pkg::ST_IDLE : sdram_burst_pkg::ST_READ;
                        end
                     end
                  end
                  sdram_burst_pkg::CMD_TERMINATE: begin
                     // data with the terminate is dropped
                     next_wr_en   = 1'b0;
                     next_rd_pipe[0] = 1'b0;
                     next_state   = sdram_burst_pkg::ST_IDLE;
                  end
                  sdram_burst_pkg::CMD_PRECHARGE: begin
                     for (int b = 0; b < 4; b++) begin
                        // one or all banks
                        if (s_addr[sdram_burst_pkg::ALL_BANK_BIT] || 2'(b) == s_ba) begin
                           if (timer[b] != 4'h0) next_error = 1'b1;
                           next_open[b]  = 1'b0;
                           next_timer[b] = 4'(sdram_burst_pkg::PRECHARGE_CYCLES - 1);
                        end
                     end
                     // truncates a burst on a closed bank
                     if (s_addr[sdram_burst_pkg::ALL_BANK_BIT] || s_ba == bank) begin
                        next_wr_en      = 1'b0;
                        next_rd_pipe[0] = 1'b0;
                        next_state      = sdram_burst_pkg::ST_IDLE;
                     end
                  end
                  default: next_error = 1'b0;
               endcase
            end
         end
      endcase
      if (rd_pipe == '0 && next_rd_pipe == '0) next_float_hold = 1'b0;
      // output stage: cas latency and two-clock mask latency
      next_rd_en = next_rd_pipe[0];
      next_oe_n  = 1'b1;
      if (rd_pipe[cas_latency - 2'h1] && !dqm_pipe[1] && !float_hold && !next_float_hold && !next_wr_en)
         next_oe_n = 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state      <= sdram_burst_pkg::ST_IDLE;
         col        <= '0;
         left       <= '0;
         bank       <= '0;
         full_page  <= 1'b0;
         open_q     <= '0;
         rd_pipe    <= '0;
         dqm_prev   <= 1'b0;
         dqm_pipe   <= '0;
         cke_prev   <= 1'b1;
         float_hold <= 1'b0;
         wr_en      <= 1'b0;
         rd_en      <= 1'b0;
         wr_data    <= '0;
         dq_oe_n    <= 1'b1;
         cmd_error  <= 1'b0;
         power_down <= 1'b0;
         active_power_down <= 1'b0;
         for (int b = 0; b < 4; b++) timer[b] <= sdram_burst_pkg::TIMER_RESET;
      end else begin
         state      <= next_state;
         col        <= next_col;
         left       <= next_left;
         bank       <= next_bank;
         full_page  <= next_full_page;
         open_q     <= next_open;
         rd_pipe    <= next_rd_pipe;
         dqm_prev   <= next_dqm_prev;
         dqm_pipe   <= next_dqm_pipe;
         cke_prev   <= next_cke_prev;
         float_hold <= next_float_hold;
         wr_en      <= next_wr_en;
         rd_en      <= next_rd_en;
         wr_data    <= next_wr_data;
         dq_oe_n    <= next_oe_n;
         cmd_error  <= next_error;
         power_down <= next_pd;
         active_power_down <= next_apd;
         for (int b = 0; b < 4; b++) timer[b] <= next_timer[b];
      end
   end

   // address outputs track the burst position
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_bank   <= '0;
         wr_col    <= '0;
         rd_bank   <= '0;
         rd_col    <= '0;
         bank_open <= '0;
         dq_out    <= '0;
      end else begin
         wr_bank   <= next_bank;
         wr_col    <= next_col - COL_WIDTH'(1);
         rd_bank   <= next_bank;
         rd_col    <= next_col - COL_WIDTH'(1);
         bank_open <= next_open;
         dq_out    <= wr_data;
      end
   end
endmodule

`default_nettype wire

// File: dv/sdram_burst_asserts.sv
// port assertions for the sdram burst engine
`timescale 1ns/100ps
`default_nettype none
module sdram_burst_asserts (
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic       clock_gate,
   input wire logic       dqm,
   input wire logic       dq_oe_n,
   input wire logic       wr_en,
   input wire logic [1:0] wr_bank,
   input wire logic       rd_en,
   input wire logic [3:0] bank_open,
   input wire logic       power_down,
   input wire logic       active_power_down
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ****
   // clock-gate high run length, saturating
   // ****
   logic [2:0] gate_high;
   logic [2:0] next_gate_high;
   always_comb begin
      next_gate_high = (gate_high == 3'h7) ? gate_high : gate_high + 3'h1;
      if (!clock_gate) next_gate_high = 3'h0;
   end
   always_ff @(posedge sys_clk) begin
      gate_high <= rst_n ? next_gate_high : 3'h0;
   end
   a_pd_no_access: assert property (power_down |-> !wr_en && !rd_en)
      else $error("access while powered down");
   a_pd_floats: assert property (power_down |-> dq_oe_n)
      else $error("data driven while powered down");
   a_pd_frozen: assert property (power_down && $past(power_down) |-> $stable(bank_open))
      else $error("bank state moved in power-down");
   a_active_pd_kind: assert property (active_power_down |-> power_down && bank_open != 4'h0)
      else $error("active power-down without open bank");
   a_idle_pd_kind: assert property (power_down && !active_power_down |-> bank_open == 4'h0)
      else $error("precharge power-down with open bank");
   a_gate_exit: assert property (gate_high == 3'h6 |-> !power_down)
      else $error("power-down held with gate high");
   a_write_floats: assert property (wr_en |-> dq_oe_n)
      else $error("data driven during write");
   a_write_open: assert property (wr_en |-> bank_open[wr_bank])
      else $error("write into idle bank");
   a_mask_floats: assert property (dqm [*6] |-> dq_oe_n)
      else $error("output not masked");
endmodule
bind sdram_burst_engine sdram_burst_asserts u_asserts (
   .sys_clk(sys_clk), .rst_n(rst_n), .clock_gate(clock_gate), .dqm(dqm), .dq_oe_n(dq_oe_n),
   .wr_en(wr_en), .wr_bank(wr_bank), .rd_en(rd_en), .bank_open(bank_open), .power_down(power_down),
   .active_power_down(active_power_down));
`default_nettype wire

// File: dv/sdram_ctrl_model.sv
// external controller model driving the sdram pins
`timescale 1ns/100ps
`default_nettype none
module sdram_ctrl_model (
   input  wire logic   sys_clk,
   output logic        clock_gate,
   output logic        cs_n,
   output logic        ras_n,
   output logic        cas_n,
   output logic        we_n,
   output logic [1:0]  bank_select_inputs,
   output logic [11:0] addr,
   output logic        dqm,
   output logic [15:0] dq_in
);
   initial begin
      clock_gate = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = sdram_burst_pkg::CMD_NOP;
      bank_select_inputs = 2'h0;
      addr = 12'h000;
      dqm = 1'b1;
      dq_in = 16'h0000;
   end
   // one command a rising edge; callers space bank reuse past the timers except where an error is wanted
   task automatic issue(input logic [3:0] cmd, input logic [1:0] b, input logic [11:0] a,
                        input logic m, input logic [15:0] d);
      @(posedge sys_clk);
      {cs_n, ras_n, cas_n, we_n} <= cmd;
      bank_select_inputs <= b;
      addr <= a;
      dqm <= m;
      dq_in <= d;
   endtask
   // no word owned: data lines toggle so a stale word never looks valid
   task automatic idle(input int n, input logic gate);
      repeat (n) begin
         @(posedge sys_clk);
         {cs_n, ras_n, cas_n, we_n} <= sdram_burst_pkg::CMD_NOP;
         clock_gate <= gate;
         dq_in <= ~dq_in;
      end
   endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the sdram burst engine
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [1:0]  cl = 2'h2;
   logic [2:0]  bl = 3'h2;
   logic        clock_gate, cs_n, ras_n, cas_n, we_n, dqm;
   logic [1:0]  bank_select_inputs, wr_bank, rd_bank;
   logic [11:0] addr;
   logic [15:0] dq_in, dq_out, wr_data;
   logic [8:0]  wr_col, rd_col;
   logic [3:0]  bank_open;
   logic        dq_oe_n, wr_en, rd_en, power_down, active_power_down, cmd_error;
   logic [26:0] wq[$];
   logic [10:0] rq[$];
   int          err_seen = 0;
   int          oe_seen = 0;
   int          num_errors = 0;
   int          cmp_count = 0;
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (wr_en === 1'b1) wq.push_back({wr_bank, wr_col, wr_data});
   always @(posedge sys_clk) if (rd_en === 1'b1) rq.push_back({rd_bank, rd_col});
   always @(posedge sys_clk) if (cmd_error === 1'b1) err_seen++;
   always @(posedge sys_clk) if (dq_oe_n === 1'b0) oe_seen++;
   sdram_ctrl_model ctrl (.sys_clk(sys_clk), .clock_gate(clock_gate), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .bank_select_inputs(bank_select_inputs), .addr(addr), .dqm(dqm),
      .dq_in(dq_in));
   sdram_burst_engine DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clock_gate(clock_gate), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_inputs(bank_select_inputs), .addr(addr),
      .dqm(dqm), .dq_in(dq_in), .cas_latency(cl), .burst_length_code(bl), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .wr_en(wr_en), .wr_bank(wr_bank), .wr_col(wr_col), .wr_data(wr_data),
      .rd_en(rd_en), .rd_bank(rd_bank), .rd_col(rd_col), .bank_open(bank_open),
      .power_down(power_down), .active_power_down(active_power_down), .cmd_error(cmd_error));
   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic expect_writes(input int n, input logic [1:0] b, input logic [8:0] c, input logic [15:0] d);
      for (int i = 0; i < n; i++) begin
         check(wq.size() > 0, "write missing");
         if (wq.size() > 0) check(wq.pop_front() === {b, c + 9'(i), d + 16'(i)}, "write element");
      end
   endtask
   task automatic expect_reads(input int n, input logic [1:0] b, input logic [8:0] c);
      for (int i = 0; i < n; i++) begin
         check(rq.size() > 0, "read missing");
         if (rq.size() > 0) check(rq.pop_front() === {b, c + 9'(i)}, "read element");
      end
      check(rq.size() == 0, "read past end");
   endtask
   task automatic wait_pd(input logic lvl);
      for (int i = 0; i < 12 && power_down !== lvl; i++) @(posedge sys_clk) #1;
      check(power_down === lvl, "power-down wait");
      if (power_down !== lvl) finish_test();
   endtask
   task automatic t_write_burst();
      ctrl.issue(sdram_burst_pkg::CMD_ACTIVE, 2'h1, 12'h000, 1'b1, 16'h0000);
      ctrl.idle(3, 1'b1);
      for (int i = 0; i < 7; i++)
         ctrl.issue(i == 0 ? sdram_burst_pkg::CMD_WRITE : sdram_burst_pkg::CMD_NOP, 2'h1, 12'h008, 1'b0,
                    16'h0a00 + 16'(i));
      ctrl.idle(12, 1'b1);
      expect_writes(4, 2'h1, 9'h008, 16'h0a00);
      check(wq.size() == 0, "write past burst end");
   endtask
   task automatic t_closed_bank();
      int i;
      ctrl.issue(sdram_burst_pkg::CMD_WRITE, 2'h2, 12'h000, 1'b0, 16'h0bad);
      for (i = 0; i < 8 && cmd_error !== 1'b1; i++) @(posedge sys_clk) #1;
      check(cmd_error === 1'b1, "closed bank accepted");
      ctrl.idle(8, 1'b1);
      check(wq.size() == 0, "closed bank written");
   endtask
   task automatic t_full_page();
      bl <= sdram_burst_pkg::BURST_FULL_PAGE;
      ctrl.idle(2, 1'b1);
      ctrl.issue(sdram_burst_pkg::CMD_WRITE, 2'h1, 12'h1fe, 1'b0, 16'h0c00);
      ctrl.issue(sdram_burst_pkg::CMD_NOP, 2'h1, 12'h000, 1'b0, 16'h0c01);
      ctrl.issue(sdram_burst_pkg::CMD_NOP, 2'h1, 12'h000, 1'b0, 16'h0c02);
      ctrl.issue(sdram_burst_pkg::CMD_TERMINATE, 2'h1, 12'h000, 1'b0, 16'h0c03);
      ctrl.idle(12, 1'b1);
      expect_writes(3, 2'h1, 9'h1fe, 16'h0c00);
      check(wq.size() == 0, "terminate word stored");
   endtask
   task automatic t_truncate();
      bl <= 3'h3;
      ctrl.idle(2, 1'b1);
      ctrl.issue(sdram_burst_pkg::CMD_WRITE, 2'h1, 12'h014, 1'b0, 16'h0d00);
      ctrl.issue(sdram_burst_pkg::CMD_WRITE, 2'h1, 12'h028, 1'b0, 16'h0e00);
      ctrl.issue(sdram_burst_pkg::CMD_NOP, 2'h1, 12'h000, 1'b0, 16'h0e01);
      ctrl.issue(sdram_burst_pkg::CMD_READ, 2'h1, 12'h000, 1'b0, 16'h0fff);
      ctrl.idle(20, 1'b1);
      expect_writes(1, 2'h1, 9'h014, 16'h0d00);
      expect_writes(2, 2'h1, 9'h028, 16'h0e00);
      expect_reads(8, 2'h1, 9'h000);
      check(wq.size() == 0, "write after read");
   endtask
   task automatic t_precharge();
      ctrl.issue(sdram_burst_pkg::CMD_ACTIVE, 2'h0, 12'h000, 1'b1, 16'h0000);
      ctrl.issue(sdram_burst_pkg::CMD_ACTIVE, 2'h3, 12'h000, 1'b1, 16'h0000);
      ctrl.idle(6, 1'b1);
      check(bank_open === 4'hb, "open banks");
      ctrl.issue(sdram_burst_pkg::CMD_PRECHARGE, 2'h1, 12'h000, 1'b1, 16'h0000);
      ctrl.idle(6, 1'b1);
      check(bank_open === 4'h9, "single precharge");
      ctrl.issue(sdram_burst_pkg::CMD_PRECHARGE, 2'h1, 12'h400, 1'b1, 16'h0000);
      ctrl.idle(6, 1'b1);
      check(bank_open === 4'h0, "all-bank precharge");
   endtask
   task automatic t_power_down();
      ctrl.idle(2, 1'b0);
      wait_pd(1'b1);
      check(active_power_down === 1'b0, "precharge power-down kind");
      ctrl.idle(1, 1'b1);
      wait_pd(1'b0);
      ctrl.issue(sdram_burst_pkg::CMD_ACTIVE, 2'h2, 12'h000, 1'b1, 16'h0000);
      ctrl.idle(4, 1'b1);
      ctrl.idle(2, 1'b0);
      wait_pd(1'b1);
      check(active_power_down === 1'b1, "active power-down kind");
      ctrl.idle(1, 1'b1);
      wait_pd(1'b0);
   endtask
   task automatic t_read_turn();
      int e0;
      int o0;
      ctrl.idle(1, 1'b1);
      bl <= 3'h2;
      e0 = err_seen;
      for (int k = 2; k < 4; k++) begin
         cl <= 2'(k);
         ctrl.idle(2, 1'b1);
         o0 = oe_seen;
         ctrl.issue(sdram_burst_pkg::CMD_READ, 2'h2, 12'h010, 1'b0, 16'h0000);
         ctrl.issue(sdram_burst_pkg::CMD_NOP, 2'h2, 12'h000, 1'b0, 16'h0000);
         ctrl.issue(sdram_burst_pkg::CMD_TERMINATE, 2'h2, 12'h000, 1'b0, 16'h0000);
         ctrl.idle(10, 1'b1);
         expect_reads(2, 2'h2, 9'h010);
         check(oe_seen - o0 == 2, "terminated read drive length");
      end
      cl <= 2'h2;
      o0 = oe_seen;
      ctrl.issue(sdram_burst_pkg::CMD_READ, 2'h2, 12'h010, 1'b0, 16'h0000);
      ctrl.issue(sdram_burst_pkg::CMD_NOP, 2'h2, 12'h000, 1'b1, 16'h0000);
      ctrl.issue(sdram_burst_pkg::CMD_NOP, 2'h2, 12'h000, 1'b1, 16'h0000);
      ctrl.issue(sdram_burst_pkg::CMD_WRITE, 2'h2, 12'h020, 1'b0, 16'h1234);
      ctrl.issue(sdram_burst_pkg::CMD_NOP, 2'h2, 12'h000, 1'b1, 16'h1235);
      ctrl.idle(10, 1'b1);
      expect_reads(3, 2'h2, 9'h010);
      expect_writes(1, 2'h2, 9'h020, 16'h1234);
      check(wq.size() == 0 && oe_seen - o0 == 1 && err_seen == e0, "read to write turnaround");
      ctrl.issue(sdram_burst_pkg::CMD_READ, 2'h2, 12'h010, 1'b0, 16'h0000);
      ctrl.issue(sdram_burst_pkg::CMD_WRITE, 2'h2, 12'h020, 1'b0, 16'h6600);
      ctrl.idle(10, 1'b1);
      check(err_seen - e0 == 1, "unmasked turnaround accepted");
      rq.delete();
      wq.delete();
   endtask
   task automatic t_write_precharge();
      int e0;
      e0 = err_seen;
      ctrl.issue(sdram_burst_pkg::CMD_READ, 2'h2, 12'h010, 1'b0, 16'h0000);
      ctrl.issue(sdram_burst_pkg::CMD_NOP, 2'h2, 12'h000, 1'b0, 16'h0000);
      ctrl.issue(sdram_burst_pkg::CMD_PRECHARGE, 2'h2, 12'h000, 1'b0, 16'h0000);
      ctrl.idle(4, 1'b1);
      check(bank_open[2] === 1'b0, "read precharge");
      expect_reads(2, 2'h2, 9'h010);
      ctrl.issue(sdram_burst_pkg::CMD_ACTIVE, 2'h2, 12'h000, 1'b0, 16'h0000);
      ctrl.idle(3, 1'b1);
      ctrl.issue(sdram_burst_pkg::CMD_WRITE, 2'h2, 12'h030, 1'b0, 16'h5a00);
      ctrl.issue(sdram_burst_pkg::CMD_NOP, 2'h2, 12'h000, 1'b0, 16'h5a01);
      ctrl.issue(sdram_burst_pkg::CMD_NOP, 2'h2, 12'h000, 1'b1, 16'h5a02);
      ctrl.issue(sdram_burst_pkg::CMD_PRECHARGE, 2'h2, 12'h000, 1'b1, 16'h5a03);
      ctrl.issue(sdram_burst_pkg::CMD_ACTIVE, 2'h2, 12'h000, 1'b1, 16'h0000);
      ctrl.idle(2, 1'b1);
      ctrl.issue(sdram_burst_pkg::CMD_ACTIVE, 2'h2, 12'h000, 1'b1, 16'h0000);
      ctrl.idle(6, 1'b1);
      expect_writes(2, 2'h2, 9'h030, 16'h5a00);
      check(wq.size() == 0 && bank_open[2] === 1'b1 && err_seen - e0 == 1, "write precharge reopen");
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      #1 check(dq_oe_n === 1'b1 && wr_en === 1'b0 && bank_open === 4'h0 && cmd_error === 1'b0, "reset");
      @(posedge sys_clk) rst_n <= 1'b1;
      ctrl.idle(8, 1'b1);
      t_write_burst();
      t_closed_bank();
      t_full_page();
      t_truncate();
      t_precharge();
      t_power_down();
      t_read_turn();
      t_write_precharge();
      finish_test();
   end
endmodule
`default_nettype wire
